/* File: supply_supervisor.v */
// supply supervisor, low-voltage detect and watchdog clock select
`timescale 1ns/1ps
`include "supply_supervisor_consts.vh"
module supply_supervisor #(
  parameter POR_DELAY = `POR_DELAY_DEF
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        brownout_below,
  input  wire        supply_droop,
  input  wire        detect_below,
  input  wire        rc_osc_clk,
  input  wire        crystal_input_pin,
  input  wire        first_instr_done,
  input  wire        proc_cycle_tick,
  output reg         chain_clk,
  output reg         global_reset_n,
  output reg         crystal_osc_en,
  output reg         standby,
  output reg         irq
);

  // ===================================================================
  // pin synchronisers
  wire brown_s;
  wire droop_s;
  wire detect_s;

  level_sync u_brown (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (brownout_below),
    .dout    (brown_s)
  );
  level_sync u_droop (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (supply_droop),
    .dout    (droop_s)
  );
  level_sync u_detect (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (detect_below),
    .dout    (detect_s)
  );

  // ===================================================================
  // brown-out and power-on sequencing
  localparam ST_RUN   = 2'd0;
  localparam ST_BROWN = 2'd1;
  localparam ST_POR   = 2'd2;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [15:0] por_cnt_reg;
  reg  [15:0] por_cnt_next;
  wire        brown_rise;
  wire        por_done_evt;
  reg         brown_d_reg;

  always @* begin
    state_next   = state_reg;
    por_cnt_next = por_cnt_reg;
    case (state_reg)
      ST_RUN: begin
        if (brown_s) begin
          state_next = ST_BROWN;
        end
      end
      ST_BROWN: begin
        por_cnt_next = 16'h0000;
        if (!brown_s) begin
          state_next = ST_POR;
        end
      end
      ST_POR: begin
        if (brown_s) begin
          state_next = ST_BROWN;
        end else if (por_cnt_reg == POR_DELAY[15:0] - 16'h0001) begin
          state_next = ST_RUN;
        end else begin
          por_cnt_next = por_cnt_reg + 16'h0001;
        end
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
  end

  // sequencer starts in power-on count so a cold start also waits
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= ST_POR;
      por_cnt_reg <= 16'h0000;
      brown_d_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      por_cnt_reg <= por_cnt_next;
      brown_d_reg <= brown_s;
    end
  end

  assign brown_rise   = brown_s & ~brown_d_reg;
  assign por_done_evt = (state_reg == ST_POR) && (state_next == ST_RUN);

  // internal reset for the register file: held through brown-out and por
  wire sys_rst = (!aresetn) || (state_reg != ST_RUN);

  always @(posedge aclk) begin
    if (!aresetn) begin
      global_reset_n <= 1'b0;
      standby        <= 1'b0;
      crystal_osc_en <= 1'b0;
    end else begin
      global_reset_n <= (state_next == ST_RUN);
      // droop halts the crystal; no system clock leaves the block
      standby        <= droop_s;
      crystal_osc_en <= !droop_s && !brown_s;
    end
  end

  // ===================================================================
  // watchdog mode register with write window
  reg [7:0] wdt_mode_reg;
  reg [6:0] open_cnt_reg;
  reg       window_run_reg;
  reg       first_seen_reg;
  wire      wdt_open = window_run_reg || !first_seen_reg;

  always @(posedge aclk) begin
    if (sys_rst) begin
      open_cnt_reg   <= 7'h00;
      window_run_reg <= 1'b0;
      first_seen_reg <= 1'b0;
    end else begin
      if (!first_seen_reg && first_instr_done) begin
        first_seen_reg <= 1'b1;
        window_run_reg <= 1'b1;
      end else if (window_run_reg && proc_cycle_tick) begin
        if (open_cnt_reg == 7'd`WDT_OPEN_CYCLES - 7'd1) begin
          window_run_reg <= 1'b0;
        end
        open_cnt_reg <= open_cnt_reg + 7'h01;
      end
    end
  end

  // ===================================================================
  // clock source mux for the reset/watchdog chain
  wire use_crystal = wdt_mode_reg[`WDT_CLKSRC_BIT];

  // registered select keeps the output glitch-limited to one aclk step;
  // a true clock mux would need a glitch-free cell
  always @(posedge aclk) begin
    if (!aresetn) begin
      chain_clk <= 1'b0;
    end else begin
      chain_clk <= use_crystal ? crystal_input_pin : rc_osc_clk;
    end
  end

  // ===================================================================
  // low-voltage detect
  reg [1:0] lvd_ctrl_reg;
  wire      lvd_event = lvd_ctrl_reg[`LVD_EN_BIT] && detect_s;

  // ===================================================================
  // axi4-lite write channel
  reg        aw_held_reg;
  reg [7:0]  aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  localparam IRQ_TOP = `IRQ_W - 1;
  reg  [IRQ_TOP:0] irq_status_reg;
  reg  [IRQ_TOP:0] irq_enable_reg;

  function known_addr;
    input [7:0] a;
    begin
      known_addr = (a == `LVD_CTRL_ADDR) || (a == `WDT_MODE_ADDR) ||
                   (a == `IRQ_STATUS_ADDR) || (a == `IRQ_ENABLE_ADDR) ||
                   (a == `IRQ_CLEAR_ADDR) || (a == `SUP_STATUS_ADDR);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_addr({aw_addr_reg[7:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [7:0] wa   = {aw_addr_reg[7:2], 2'b00};
  wire       wb0  = do_write && w_strb_reg[0];

  // ===================================================================
  // register file
  always @(posedge aclk) begin
    if (sys_rst) begin
      wdt_mode_reg <= `WDT_MODE_RESET;
      lvd_ctrl_reg <= `LVD_CTRL_RESET;
    end else begin
      if (wb0 && wa == `WDT_MODE_ADDR && wdt_open) begin
        wdt_mode_reg <= w_data_reg[7:0];
      end
      // a pending detect wins over a software write of the flag
      if (wb0 && wa == `LVD_CTRL_ADDR) begin
        lvd_ctrl_reg[`LVD_EN_BIT]   <= w_data_reg[`LVD_EN_BIT];
        lvd_ctrl_reg[`LVD_FLAG_BIT] <= w_data_reg[`LVD_FLAG_BIT] || lvd_event;
      end else if (lvd_event) begin
        lvd_ctrl_reg[`LVD_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // interrupt state survives brown-out so software can see it afterwards
  wire [IRQ_TOP:0] irq_set = {por_done_evt, brown_rise, lvd_event};
  wire [IRQ_TOP:0] irq_clr = (wb0 && wa == `IRQ_CLEAR_ADDR) ?
                             w_data_reg[IRQ_TOP:0] : {`IRQ_W{1'b0}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= {`IRQ_W{1'b0}};
      irq_enable_reg <= {`IRQ_W{1'b0}};
      irq            <= 1'b0;
    end else begin
      // set wins over clear in the same cycle
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      if (wb0 && wa == `IRQ_ENABLE_ADDR) begin
        irq_enable_reg <= w_data_reg[IRQ_TOP:0];
      end
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // ===================================================================
  // axi4-lite read channel
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= known_addr(ra) ? `RESP_OKAY : `RESP_SLVERR;
        case (ra)
          `LVD_CTRL_ADDR:   s_axi_rdata <= {30'h0000_0000, lvd_ctrl_reg};
          `IRQ_STATUS_ADDR: s_axi_rdata <= {29'h0000_0000, irq_status_reg};
          `IRQ_ENABLE_ADDR: s_axi_rdata <= {29'h0000_0000, irq_enable_reg};
          `SUP_STATUS_ADDR: s_axi_rdata <= {27'h0000_000, wdt_open, droop_s,
                                            detect_s, state_reg};
          // watchdog mode and clear registers read as zero
          default:          s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // supply_supervisor

/* File: supply_supervisor_consts.vh */
// constants for the supply supervisor and watchdog clock select block
//
// Notes on behaviour
// - when the clock-source bit is one the reset/watchdog counter chain runs from the crystal input instead of the rc oscillator.
// - after reset the clock-source bit reads zero so the rc oscillator clocks the chain.
// - reset is driven to all logic for as long as the brown-out comparator reports low supply; the code keeps the interrupt registers through it.
// - once the supply is back above the brown-out threshold a full power-on reset sequence runs before normal operation.
// - a small supply droop stops the crystal oscillator and enters a low-voltage standby with no system clock.
// - the low-voltage detector control sits at offset 0x0c and its bit 0 enables detection.
// - bit 1 of that register is a flag set when the enabled detector sees the supply reach the detection threshold.
// - the watchdog mode register at offset 0x0f is write-only and reads never return it.
// - the watchdog mode register takes writes only in the first 61 processor cycles after the first instruction following reset, then locks;
//   the code also takes writes before that first instruction.
`ifndef SUPPLY_SUPERVISOR_CONSTS_VH
`define SUPPLY_SUPERVISOR_CONSTS_VH

// =====================================================================
// register map; the two documented registers keep their word index,
// and their byte address is four times that index
`define LVD_CTRL_IDX     8'h0c
`define WDT_MODE_IDX     8'h0f
`define LVD_CTRL_ADDR    8'h30
`define WDT_MODE_ADDR    8'h3c
`define IRQ_STATUS_ADDR  8'h10
`define IRQ_ENABLE_ADDR  8'h14
`define IRQ_CLEAR_ADDR   8'h18
`define SUP_STATUS_ADDR  8'h1c

// =====================================================================
// field positions
`define LVD_EN_BIT       0
`define LVD_FLAG_BIT     1
`define WDT_CLKSRC_BIT   4
`define IRQ_LVD_BIT      0
`define IRQ_BROWN_BIT    1
`define IRQ_RECOV_BIT    2
`define IRQ_W            3

// =====================================================================
// reset values and timing
`define WDT_MODE_RESET   8'h0e
`define LVD_CTRL_RESET   2'h0
`define WDT_OPEN_CYCLES  61
`define POR_DELAY_DEF    16
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* File: level_sync.v */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module level_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // change is accepted only once stages two and three agree
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // level_sync

/* File: supply_supervisor_properties.sv */
// port assertions for the supply supervisor
`timescale 1ns/1ps
module supply_supervisor_properties #(
  parameter POR_DELAY = 16
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        brownout_below,
  input wire        supply_droop,
  input wire        rc_osc_clk,
  input wire        crystal_input_pin,
  input wire        global_reset_n,
  input wire        crystal_osc_en,
  input wire        standby,
  input wire        chain_clk,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  // synchroniser and filter add a few cycles on top of the count
  localparam int POR_MAX = POR_DELAY + 24;
  localparam int POR_BACK = POR_DELAY - 1;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // =====================================================================
  // supply supervision
  a_brown_reset: assert property (brownout_below [*8] |-> !global_reset_n && !crystal_osc_en)
    else $error("reset not held during brownout");
  a_por_wait: assert property ($fell(brownout_below) |-> ##[1:POR_MAX] global_reset_n)
    else $error("no recovery after brownout");
  a_por_count: assert property ($rose(global_reset_n) |-> $past(global_reset_n, POR_BACK) == 1'b0)
    else $error("power-on count too short");
  a_droop_standby: assert property (supply_droop [*8] |-> standby && !crystal_osc_en)
    else $error("no standby on droop");
  a_droop_gone: assert property (!supply_droop [*8] |-> !standby)
    else $error("standby without droop");
  // =====================================================================
  // counter chain clock
  a_chain_mux: assert property ($past(aresetn) && $past(rc_osc_clk) == $past(crystal_input_pin)
    |-> chain_clk == $past(rc_osc_clk))
    else $error("chain clock from neither source");
  a_chain_default: assert property ($rose(aresetn) |=> chain_clk == $past(rc_osc_clk))
    else $error("chain clock not rc after reset");
  // =====================================================================
  // bus answers stand until taken
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // supply_supervisor_properties

bind supply_supervisor supply_supervisor_properties #(.POR_DELAY(POR_DELAY)) u_props (
  .aclk(aclk), .aresetn(aresetn), .brownout_below(brownout_below), .supply_droop(supply_droop),
  .rc_osc_clk(rc_osc_clk), .crystal_input_pin(crystal_input_pin), .global_reset_n(global_reset_n),
  .crystal_osc_en(crystal_osc_en), .standby(standby), .chain_clk(chain_clk),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

/* File: supply_supervisor_tb.sv */
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
`include "supply_supervisor_consts.vh"
module supply_supervisor_tb;
  localparam POR = 4;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        brownout_below = 0, supply_droop = 0, detect_below = 0;
  logic        rc_osc_clk = 0, crystal_input_pin = 0, first_instr_done = 0, proc_cycle_tick = 0;
  logic        chain_clk, global_reset_n, crystal_osc_en, standby, irq, rc_d, xt_d;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  int          error_cnt = 0, checks_done = 0, n;

  supply_supervisor #(.POR_DELAY(POR)) u_dut (.*);

  initial forever #10 aclk = ~aclk;

  // both sources random so a wrong select shows within a few cycles
  always @(posedge aclk) begin
    rc_osc_clk <= 1'($urandom);
    crystal_input_pin <= 1'($urandom);
    rc_d <= rc_osc_clk;
    xt_d <= crystal_input_pin;
  end

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // =====================================================================
  // bus answers are compared against the oldest note
  always @(posedge aclk) begin
    logic [65:0] e;
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", 32'(bq.pop_front()), 32'(s_axi_bresp));
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      cmp("rresp", 32'(e[65:64]), 32'(s_axi_rresp));
      cmp("rdata", e[31:0], s_axi_rdata & e[63:32]);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
    rq.push_back({r, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask

  task automatic wait_por(output int k);
    k = 0;
    while (global_reset_n !== 1'b1 && k < 300) begin
      @(posedge aclk);
      k++;
    end
  endtask

  task automatic chain(input logic xt);
    repeat (2) @(posedge aclk);
    repeat (8) begin
      @(posedge aclk);
      cmp("chain_clk", 32'(xt ? xt_d : rc_d), 32'(chain_clk));
    end
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      proc_cycle_tick <= 1;
      @(posedge aclk);
      proc_cycle_tick <= 0;
      @(posedge aclk);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // =====================================================================
  // main sequence
  initial begin
    void'($urandom(32'h4d16));
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    wait_por(n);
    cmp("por_min", 1, 32'(n >= POR));
    rd(`LVD_CTRL_ADDR, 0, 3, `RESP_OKAY);
    chain(0);
    wr(`WDT_MODE_ADDR, 32'h1e, `RESP_OKAY);
    chain(1);
    rd(`WDT_MODE_ADDR, 0, 32'h10, `RESP_OKAY);
    first_instr_done <= 1;
    @(posedge aclk);
    first_instr_done <= 0;
    tick(58);
    wr(`WDT_MODE_ADDR, 32'h0e, `RESP_OKAY);
    chain(0);
    tick(6);
    wr(`WDT_MODE_ADDR, 32'h1e, `RESP_OKAY);
    chain(0);
    wr(`IRQ_ENABLE_ADDR, 1, `RESP_OKAY);
    wr(`LVD_CTRL_ADDR, 1, `RESP_OKAY);
    detect_below <= 1;
    repeat (8) @(posedge aclk);
    rd(`LVD_CTRL_ADDR, 3, 3, `RESP_OKAY);
    rd(`IRQ_STATUS_ADDR, 1, 1, `RESP_OKAY);
    cmp("irq", 1, 32'(irq));
    wr(`IRQ_ENABLE_ADDR, 0, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp("irq", 0, 32'(irq));
    detect_below <= 0;
    wr(`LVD_CTRL_ADDR, 1, `RESP_OKAY);
    wr(`IRQ_CLEAR_ADDR, 7, `RESP_OKAY);
    rd(`IRQ_STATUS_ADDR, 0, 1, `RESP_OKAY);
    wr(`IRQ_ENABLE_ADDR, 1, `RESP_OKAY);
    wr(`LVD_CTRL_ADDR, 0, `RESP_OKAY);
    detect_below <= 1;
    repeat (8) @(posedge aclk);
    rd(`LVD_CTRL_ADDR, 0, 3, `RESP_OKAY);
    wr(`LVD_CTRL_ADDR, 1, `RESP_OKAY);
    wr(8'h40, 0, `RESP_SLVERR);
    rd(8'h40, 0, 0, `RESP_SLVERR);
    // brownout then recovery must bring back reset values
    brownout_below <= 1;
    detect_below <= 0;
    repeat (10) @(posedge aclk);
    cmp("global_reset_n", 0, 32'(global_reset_n));
    cmp("crystal_osc_en", 0, 32'(crystal_osc_en));
    brownout_below <= 0;
    wait_por(n);
    cmp("por_span", 1, 32'(n >= POR && n <= POR + 12));
    rd(`LVD_CTRL_ADDR, 0, 3, `RESP_OKAY);
    chain(0);
    wr(`WDT_MODE_ADDR, 32'h1e, `RESP_OKAY);
    chain(1);
    supply_droop <= 1;
    repeat (10) @(posedge aclk);
    cmp("standby", 1, 32'(standby));
    cmp("crystal_osc_en", 0, 32'(crystal_osc_en));
    supply_droop <= 0;
    repeat (10) @(posedge aclk);
    cmp("standby", 0, 32'(standby));
    test_done;
  end

  initial begin
    #400_000;
    error_cnt++;
    test_done;
  end
endmodule // supply_supervisor_tb
